/* File: verilog/cpu_bus_command_controller.sv */
// Bus command controller: status decode to commands and controls
module cpu_bus_command_controller (
  input wire logic mclk_in, // System clock, falling edge used
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic status_bit0_n_in, // Status line 0, active low
  input wire logic status_bit1_n_in, // Status line 1, active low
  input wire logic space_select_in, // High memory, low I/O
  input wire logic latched_select_in, // Controller select
  input wire logic command_hold_in, // Delays command start
  input wire logic ready_n_in, // Ends cycle, active low
  input wire logic shared_enable_pin_in, // Grant or gate pin
  input wire logic timing_mode_strap_in, // High: compatible timing
  output logic io_write_cmd_n_out, // I/O write command
  output logic io_read_cmd_n_out, // I/O read command
  output logic mem_write_cmd_n_out, // Memory write command
  output logic mem_read_cmd_n_out, // Memory read command
  output logic interrupt_ack_cmd_n_out, // Interrupt acknowledge
  output logic cmd_oe_out, // Command drivers enabled
  output logic address_latch_strobe_out, // Address latch enable
  output logic cascade_addr_enable_out, // Cascade address enable
  output logic data_xcvr_enable_out, // Transceiver enable
  output logic xfer_direction_out // High write or idle, low read
);

  // Whole state of the block in one register
  typedef struct packed {
    logic [bus_cmd_pkg::IN_W-1:0] meta; // First sync stage
    logic [bus_cmd_pkg::IN_W-1:0] sync; // Second sync stage
    bus_cmd_pkg::bus_state_t state; // Bus state
    bus_cmd_pkg::cycle_type_t ctype; // Cycle being run
    logic selected; // Select captured at status end
    logic armed; // Command activation point passed
    logic cmd_pending; // Command due, held off
    logic cmd_on; // Command active
    logic [2:0] rdy_cnt; // Ready low run length
    logic ale; // Address latch strobe
    logic cascade_addr_enable; // Cascade enable
    logic data_xcvr_enable; // Transceiver enable
    logic dir; // Transfer direction
    logic drive; // Command output enable
    logic [bus_cmd_pkg::CMD_W-1:0] cmd_n; // Commands
  } ctl_t;

  // Reset image: idle bus, quiet inputs, outputs inactive
  localparam ctl_t CTL_RESET = '{
    meta: bus_cmd_pkg::IN_RESET,
    sync: bus_cmd_pkg::IN_RESET,
    state: bus_cmd_pkg::idle_state,
    ctype: bus_cmd_pkg::cyc_idle_b,
    selected: 1'h0,
    armed: 1'h0,
    cmd_pending: 1'h0,
    cmd_on: 1'h0,
    rdy_cnt: 3'h0,
    ale: 1'h0,
    cascade_addr_enable: 1'h0,
    data_xcvr_enable: 1'h0,
    dir: 1'h1,
    drive: 1'h1,
    cmd_n: bus_cmd_pkg::CMD_IDLE
  };

  ctl_t s; // Current state
  ctl_t next_s; // Next state

  // Decoded views of the synchronised inputs
  logic compat; // Compatible bus timing selected
  logic start; // A status line is low
  logic rdy_low; // Ready sampled low
  logic hold; // Command hold sampled high
  logic gate_ok; // Grant or gate allows commands
  logic due; // Activation point reached this edge
  logic in_cycle; // Next state lies inside a cycle
  logic in_cmd; // Next state is a command state
  logic is_read; // Current cycle reads
  logic is_write; // Current cycle writes
  logic want_den; // Transceiver enable wanted
  logic want_dir; // Direction wanted
  bus_cmd_pkg::cycle_type_t new_type; // Type on the lines now

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    // Every pin passes two flops before use; the first
    // stage feeds only the second, so metastability stays
    // out of the decode at the cost of two edges of lag.
    next_s.meta[bus_cmd_pkg::IN_S0] = status_bit0_n_in;
    next_s.meta[bus_cmd_pkg::IN_S1] = status_bit1_n_in;
    next_s.meta[bus_cmd_pkg::IN_SPACE] = space_select_in;
    next_s.meta[bus_cmd_pkg::IN_LSEL] = latched_select_in;
    next_s.meta[bus_cmd_pkg::IN_HOLD] = command_hold_in;
    next_s.meta[bus_cmd_pkg::IN_RDY] = ready_n_in;
    next_s.meta[bus_cmd_pkg::IN_SHARED] = shared_enable_pin_in;
    next_s.meta[bus_cmd_pkg::IN_STRAP] = timing_mode_strap_in;
    next_s.sync = s.meta;

    // Input decode from the second stage only
    compat = (s.sync[bus_cmd_pkg::IN_STRAP] == bus_cmd_pkg::STRAP_COMPAT);
    start = !s.sync[bus_cmd_pkg::IN_S0] || !s.sync[bus_cmd_pkg::IN_S1];
    rdy_low = !s.sync[bus_cmd_pkg::IN_RDY];
    hold = s.sync[bus_cmd_pkg::IN_HOLD];
    new_type = bus_cmd_pkg::cycle_type_t'({s.sync[bus_cmd_pkg::IN_SPACE],
      s.sync[bus_cmd_pkg::IN_S1], s.sync[bus_cmd_pkg::IN_S0]});

    // Pin meaning follows the strap
    if (compat) begin
      gate_ok = !s.sync[bus_cmd_pkg::IN_SHARED];
    end else begin
      gate_ok = s.sync[bus_cmd_pkg::IN_SHARED];
    end

    // Ready low run counter, saturating
    if (rdy_low) begin
      if (s.rdy_cnt != bus_cmd_pkg::RDY_HOLD_EDGES) begin
        next_s.rdy_cnt = s.rdy_cnt + 3'h1;
      end
    end else begin
      next_s.rdy_cnt = 3'h0;
    end

    // Bus state machine; each state here is one phase
    due = 1'b0;
    case (s.state)
      // Idle and halt both wait for a status line; halt
      // ignores every control input meanwhile
      bus_cmd_pkg::idle_state, bus_cmd_pkg::halt_state: begin
        if (start) begin
          next_s.ctype = new_type;
          next_s.selected = 1'b0;
          next_s.armed = 1'b0;
          if (new_type == bus_cmd_pkg::cyc_halt) begin
            next_s.state = bus_cmd_pkg::halt_state;
          end else begin
            next_s.state = bus_cmd_pkg::status_state;
          end
        end
      end
      // Second status phase: capture select, enter command
      bus_cmd_pkg::status_state: begin
        next_s.selected = s.sync[bus_cmd_pkg::IN_LSEL];
        next_s.state = bus_cmd_pkg::command_state_a;
        due = s.sync[bus_cmd_pkg::IN_LSEL] && !compat;
      end
      // First command phase; compatible mode starts late
      bus_cmd_pkg::command_state_a: begin
        next_s.state = bus_cmd_pkg::command_state_b;
        due = s.selected && compat && !s.armed;
      end
      // Second command phase: ready decides
      bus_cmd_pkg::command_state_b: begin
        if (rdy_low) begin
          // End, whether or not a command ever went out
          next_s.cmd_on = 1'b0;
          next_s.cmd_pending = 1'b0;
          next_s.selected = 1'b0;
          next_s.armed = 1'b0;
          if (start) begin
            // Back to back: straight into a new status
            next_s.ctype = new_type;
            if (new_type == bus_cmd_pkg::cyc_halt) begin
              next_s.state = bus_cmd_pkg::halt_state;
            end else begin
              next_s.state = bus_cmd_pkg::status_state;
            end
          end else begin
            next_s.state = bus_cmd_pkg::idle_state;
          end
        end else begin
          // Wait state: back to the first command phase, where a held-off command can still start
          next_s.state = bus_cmd_pkg::command_state_a;
        end
      end
      default: begin
        next_s.state = bus_cmd_pkg::idle_state;
      end
    endcase

    // Command activation, gated by hold each edge
    if (due) begin
      next_s.armed = 1'b1;
    end
    if ((due || s.cmd_pending) && next_s.state != bus_cmd_pkg::idle_state
        && next_s.state != bus_cmd_pkg::halt_state && !(s.state == bus_cmd_pkg::command_state_b && rdy_low)) begin
      if (hold) begin
        next_s.cmd_pending = 1'b1;
      end else begin
        next_s.cmd_pending = 1'b0;
        next_s.cmd_on = 1'b1;
      end
    end

    // Ready held low behaves as a reset to idle; a single
    // low at a cycle end cannot reach the threshold
    if (s.rdy_cnt == bus_cmd_pkg::RDY_HOLD_EDGES) begin
      next_s.state = bus_cmd_pkg::idle_state;
      next_s.cmd_on = 1'b0;
      next_s.cmd_pending = 1'b0;
      next_s.selected = 1'b0;
      next_s.armed = 1'b0;
    end

    // Cycle classification for the outputs
    in_cycle = (next_s.state == bus_cmd_pkg::status_state)
      || (next_s.state == bus_cmd_pkg::command_state_a)
      || (next_s.state == bus_cmd_pkg::command_state_b);
    in_cmd = (next_s.state == bus_cmd_pkg::command_state_a)
      || (next_s.state == bus_cmd_pkg::command_state_b);
    is_read = (next_s.ctype == bus_cmd_pkg::cyc_interrupt_ack_cmd)
      || (next_s.ctype == bus_cmd_pkg::cyc_io_read)
      || (next_s.ctype == bus_cmd_pkg::cyc_mem_read);
    is_write = (next_s.ctype == bus_cmd_pkg::cyc_io_write)
      || (next_s.ctype == bus_cmd_pkg::cyc_mem_write);

    // Strobes in the status phase, blind to control inputs
    next_s.ale = (next_s.state == bus_cmd_pkg::status_state);
    next_s.cascade_addr_enable = next_s.ale && (next_s.ctype == bus_cmd_pkg::cyc_interrupt_ack_cmd);

    // Command lines: idle high unless active and allowed
    next_s.cmd_n = bus_cmd_pkg::CMD_IDLE;
    if (next_s.cmd_on && gate_ok) begin
      case (next_s.ctype)
        bus_cmd_pkg::cyc_io_write: begin
          next_s.cmd_n[bus_cmd_pkg::CMD_IOW] = 1'b0;
        end
        bus_cmd_pkg::cyc_io_read: begin
          next_s.cmd_n[bus_cmd_pkg::CMD_IOR] = 1'b0;
        end
        bus_cmd_pkg::cyc_mem_write: begin
          next_s.cmd_n[bus_cmd_pkg::CMD_MWT] = 1'b0;
        end
        bus_cmd_pkg::cyc_mem_read: begin
          next_s.cmd_n[bus_cmd_pkg::CMD_MRD] = 1'b0;
        end
        bus_cmd_pkg::cyc_interrupt_ack_cmd: begin
          next_s.cmd_n[bus_cmd_pkg::CMD_INTERRUPT_ACK_CMD] = 1'b0;
        end
        default: begin
          next_s.cmd_n = bus_cmd_pkg::CMD_IDLE;
        end
      endcase
    end
    // Grant released in compatible mode: float the commands
    next_s.drive = compat ? gate_ok : 1'b1;

    // Transceiver enable; compatible writes wait for arming
    want_den = next_s.selected && gate_ok && in_cmd
      && (is_read || is_write)
      && !(is_write && compat && !next_s.armed);

    // Direction low only inside a read cycle
    want_dir = !(in_cycle && is_read);

    // Direction moves only while enable is and stays off,
    // and enable rises only once direction is settled
    if (!s.data_xcvr_enable) begin
      next_s.dir = want_dir;
    end
    next_s.data_xcvr_enable = want_den && (s.dir == want_dir);
  end

  // One register for everything, on the falling edge so
  // inputs are sampled and outputs change only there
  always_ff @(negedge mclk_in) begin
    if (rst_in) begin
      s <= CTL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign io_write_cmd_n_out = s.cmd_n[bus_cmd_pkg::CMD_IOW];
  assign io_read_cmd_n_out = s.cmd_n[bus_cmd_pkg::CMD_IOR];
  assign mem_write_cmd_n_out = s.cmd_n[bus_cmd_pkg::CMD_MWT];
  assign mem_read_cmd_n_out = s.cmd_n[bus_cmd_pkg::CMD_MRD];
  assign interrupt_ack_cmd_n_out = s.cmd_n[bus_cmd_pkg::CMD_INTERRUPT_ACK_CMD];
  assign cmd_oe_out = s.drive;
  assign address_latch_strobe_out = s.ale;
  assign cascade_addr_enable_out = s.cascade_addr_enable;
  assign data_xcvr_enable_out = s.data_xcvr_enable;
  assign xfer_direction_out = s.dir;

endmodule // cpu_bus_command_controller

/* File: verilog/bus_cmd_pkg.sv */
// Constants and types for the local bus command controller
// Function
// - Sample and change outputs on falling edge
// - Either status line low starts a cycle
// - Decode cycle type from space and status
// - Strap selects compatible or short timing
// - Latch select at status end, gate response
// - Hold withholds command, resampled every clock
// - Early ready ends cycle without command
// - Ready held low forces idle state
// - Shared enable pin synchronised through two flops like the rest
// - Strap high: pin is bus grant, tristates
// - Strap low: pin gates, outputs stay driven
// - Address strobe every cycle except halt
// - Cascade enable only on interrupt acknowledge
// - Transceiver enable, delayed for compatible writes
// - Direction high write/idle, low read, safe
// - Five active-low commands by cycle type
// - Idle, status, command states, back to back
// - Ready high repeats command state as wait
// - Compatible mode delays every command one clock
// - Halt drives nothing, ignores control inputs
package bus_cmd_pkg;
  // Bit positions in the sampled input vector
  localparam int IN_W = 8;
  localparam int IN_S0 = 0;
  localparam int IN_S1 = 1;
  localparam int IN_SPACE = 2;
  localparam int IN_LSEL = 3;
  localparam int IN_HOLD = 4;
  localparam int IN_RDY = 5;
  localparam int IN_SHARED = 6;
  localparam int IN_STRAP = 7;
  // Quiet input value: status high, ready high
  localparam logic [IN_W-1:0] IN_RESET = 8'h23;
  // Command vector bit positions, all active low
  localparam int CMD_W = 5;
  localparam int CMD_IOW = 0;
  localparam int CMD_IOR = 1;
  localparam int CMD_MWT = 2;
  localparam int CMD_MRD = 3;
  localparam int CMD_INTERRUPT_ACK_CMD = 4;
  localparam logic [CMD_W-1:0] CMD_IDLE = 5'h1f;
  // Edges of ready low in a row, a command end included, that reset the bus
  localparam logic [2:0] RDY_HOLD_EDGES = 3'h4;
  // Strap level selecting compatible system bus timing
  localparam logic STRAP_COMPAT = 1'h1;
  // Bus states, one per processor clock phase
  typedef enum logic [2:0] {
    idle_state = 3'b000,
    status_state = 3'b001,
    command_state_a = 3'b010,
    command_state_b = 3'b011,
    halt_state = 3'b100
  } bus_state_t;
  // Cycle types as {space_select, status_bit1, status_bit0}
  typedef enum logic [2:0] {
    cyc_interrupt_ack_cmd = 3'b000,
    cyc_io_read = 3'b001,
    cyc_io_write = 3'b010,
    cyc_idle_a = 3'b011,
    cyc_halt = 3'b100,
    cyc_mem_read = 3'b101,
    cyc_mem_write = 3'b110,
    cyc_idle_b = 3'b111
  } cycle_type_t;
endpackage

/* File: dv/bus_master_model.sv */
// Local bus master model that drives the status and space lines
module bus_master_model (
  input wire logic mclk_in, // System clock
  output logic status_bit0_n_out, // Status line 0
  output logic status_bit1_n_out, // Status line 1
  output logic space_select_out // Memory or I/O space
);
  timeunit 1ns;
  timeprecision 1ps;
  // Status lines idle high, space low, until a cycle is asked for
  initial begin
    status_bit0_n_out = 1'b1;
    status_bit1_n_out = 1'b1;
    space_select_out = 1'b0;
  end
  // One status state of two clocks, then idle; space is not held past it
  task automatic run(input logic [2:0] kind);
    @(posedge mclk_in);
    #1 {space_select_out, status_bit1_n_out, status_bit0_n_out} = kind;
    repeat (2) @(posedge mclk_in);
    #1 {status_bit1_n_out, status_bit0_n_out} = 2'h3;
    space_select_out = ~kind[2];
  endtask
endmodule // bus_master_model

/* File: dv/cpu_bus_command_controller_props.sv */
// Concurrent checks on the bus command controller ports
module cpu_bus_command_controller_props (
  input wire logic mclk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic status_bit0_n_in, // Status 0
  input wire logic status_bit1_n_in, // Status 1
  input wire logic space_select_in, // Space
  input wire logic latched_select_in, // Select
  input wire logic command_hold_in, // Hold
  input wire logic ready_n_in, // Ready
  input wire logic shared_enable_pin_in, // Grant or gate
  input wire logic timing_mode_strap_in, // Strap
  input wire logic io_write_cmd_n_out, // Command
  input wire logic io_read_cmd_n_out, // Command
  input wire logic mem_write_cmd_n_out, // Command
  input wire logic mem_read_cmd_n_out, // Command
  input wire logic interrupt_ack_cmd_n_out, // Command
  input wire logic cmd_oe_out, // Drive enable
  input wire logic address_latch_strobe_out, // Strobe
  input wire logic cascade_addr_enable_out, // Cascade
  input wire logic data_xcvr_enable_out, // Enable
  input wire logic xfer_direction_out // Direction
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [4:0] cmd = {interrupt_ack_cmd_n_out, mem_read_cmd_n_out, mem_write_cmd_n_out, io_read_cmd_n_out,
    io_write_cmd_n_out}; // All commands, active low
  logic [2:0] rdy_age; // Edges since ready was low, saturating
  // Age of the last ready low, so a command end can be tied to it
  always_ff @(negedge mclk_in) begin
    rdy_age <= !ready_n_in ? 3'h0 : (rdy_age == 3'h7 ? rdy_age : rdy_age + 3'h1);
  end
  default clocking cb @(negedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_strobe_pulse; address_latch_strobe_out |=> !address_latch_strobe_out; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one clock");
  property p_cascade; cascade_addr_enable_out |-> address_latch_strobe_out; endproperty
  a_cascade: assert property (p_cascade) else $error("cascade without strobe");
  property p_one_cmd; $onehot0(~cmd); endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("two commands at once");
  property p_wr_dir; !(io_write_cmd_n_out && mem_write_cmd_n_out) |-> xfer_direction_out; endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("write with direction low");
  property p_rd_dir; !(&cmd[4:3] && cmd[1]) |-> !xfer_direction_out; endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("read with direction high");
  property p_dir_en; $changed(xfer_direction_out) |-> !data_xcvr_enable_out && !$past(data_xcvr_enable_out); endproperty
  a_dir_en: assert property (p_dir_en) else $error("direction moved while enabled");
  property p_gate; (!timing_mode_strap_in && !shared_enable_pin_in)[*5] |-> &cmd && !data_xcvr_enable_out && cmd_oe_out;
  endproperty
  a_gate: assert property (p_gate) else $error("gate off but outputs active");
  property p_grant; (timing_mode_strap_in && shared_enable_pin_in)[*5] |-> !cmd_oe_out && !data_xcvr_enable_out; endproperty
  a_grant: assert property (p_grant) else $error("no grant but drivers on");
  property p_rdy_end; $rose(&cmd) |-> rdy_age <= 3'h4; endproperty
  a_rdy_end: assert property (p_rdy_end) else $error("command ended without ready");
  property p_hold; $fell(&cmd) |-> !$past(command_hold_in, 3); endproperty
  a_hold: assert property (p_hold) else $error("command started during hold");
endmodule // cpu_bus_command_controller_props
bind cpu_bus_command_controller cpu_bus_command_controller_props props (.*);

/* File: dv/cpu_bus_command_controller_tb.sv */
// Self-checking testbench for the bus command controller
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cpu_bus_command_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0; // System clock
  logic rst_in = 1'b1; // Reset
  logic latched_select_in = 1'b1; // Controller select
  logic command_hold_in = 1'b0; // Command delay
  logic ready_n_in = 1'b0; // Low through reset
  logic shared_enable_pin_in = 1'b1; // Grant or gate
  logic timing_mode_strap_in = 1'b0; // Short timing
  logic status_bit0_n_in, status_bit1_n_in, space_select_in; // From the master model
  logic io_write_cmd_n_out, io_read_cmd_n_out, mem_write_cmd_n_out, mem_read_cmd_n_out; // Commands
  logic interrupt_ack_cmd_n_out, cmd_oe_out, address_latch_strobe_out; // Outputs
  logic cascade_addr_enable_out, data_xcvr_enable_out, xfer_direction_out; // Outputs
  wire [4:0] cmd_n = {interrupt_ack_cmd_n_out, mem_read_cmd_n_out, mem_write_cmd_n_out, io_read_cmd_n_out,
    io_write_cmd_n_out}; // Commands by package position
  logic [9:0] seen; // Sticky: commands, strobe, cascade, read dir, enable, early enable
  int fails = 0;
  int cmp_count = 0;
  bus_master_model bus_master (
    .mclk_in(mclk_in),
    .status_bit0_n_out(status_bit0_n_in),
    .status_bit1_n_out(status_bit1_n_in),
    .space_select_out(space_select_in)
  );
  cpu_bus_command_controller dut (.*);
  // Clock, 10 ns period
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  // Outputs settle on the falling edge, so collect them on the rising one
  always @(posedge mclk_in) begin
    seen <= seen | {timing_mode_strap_in & data_xcvr_enable_out & xfer_direction_out & (&cmd_n) & ~|seen[4:0],
      data_xcvr_enable_out, ~xfer_direction_out, cascade_addr_enable_out, address_latch_strobe_out, ~cmd_n};
  end
  // Reset with ready low; strap and shared pin only change here
  task automatic do_reset(input logic strap, input logic shared);
    @(posedge mclk_in);
    #1 rst_in = 1'b1;
    ready_n_in = 1'b0;
    timing_mode_strap_in = strap;
    shared_enable_pin_in = shared;
    repeat (8) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    ready_n_in = 1'b1;
  endtask
  // One bus cycle: wait states, then ready held low long enough to end it
  task automatic run_cycle(input logic [2:0] kind, input logic sel, input int hold);
    logic [4:0] exp;
    logic ok;
    int n;
    ok = sel && (timing_mode_strap_in ? !shared_enable_pin_in : shared_enable_pin_in);
    case (kind)
      3'h0: exp = 5'h01 << bus_cmd_pkg::CMD_INTERRUPT_ACK_CMD;
      3'h1: exp = 5'h01 << bus_cmd_pkg::CMD_IOR;
      3'h2: exp = 5'h01 << bus_cmd_pkg::CMD_IOW;
      3'h5: exp = 5'h01 << bus_cmd_pkg::CMD_MRD;
      3'h6: exp = 5'h01 << bus_cmd_pkg::CMD_MWT;
      default: exp = 5'h00;
    endcase
    @(posedge mclk_in);
    #1 latched_select_in = sel;
    command_hold_in = (hold != 0);
    seen = '0;
    bus_master.run(kind);
    repeat (hold) @(posedge mclk_in);
    if (hold != 0) `CHK(seen[4:0], 5'h00)
    #1 command_hold_in = 1'b0;
    n = 0;
    while (&cmd_n && n < 12) begin
      @(posedge mclk_in);
      n++;
    end
    repeat (3) @(posedge mclk_in);
    `CHK(cmd_n, ~exp & {5{ok}} ^ 5'h1f ^ 5'h1f | ~({5{ok}} & exp))
    #1 ready_n_in = 1'b0;
    repeat (8) @(posedge mclk_in);
    #1 ready_n_in = 1'b1;
    repeat (4) @(posedge mclk_in);
    `CHK(seen[4:0], ok ? exp : 5'h00)
    `CHK(seen[5], kind inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})
    `CHK(seen[6], kind == 3'h0)
    `CHK(seen[7], kind inside {3'h0, 3'h1, 3'h5})
    `CHK(seen[8], ok && exp != 5'h00)
    `CHK(seen[9], 1'b0)
    `CHK({cmd_n, xfer_direction_out}, 6'h3f)
    `CHK(cmd_oe_out, ~(timing_mode_strap_in & shared_enable_pin_in))
  endtask
  // Every status code in short timing
  task automatic t_all_types();
    for (int k = 0; k < 8; k++) begin
      run_cycle(3'(k), 1'b1, 0);
    end
  endtask
  // Deselected cycle, then a long command hold
  task automatic t_select_hold();
    run_cycle(3'h1, 1'b0, 0);
    run_cycle(3'h5, 1'b1, 6);
  endtask
  // Gate low in short timing, grant off in compatible timing
  task automatic t_gate_grant();
    do_reset(1'b0, 1'b0);
    run_cycle(3'h6, 1'b1, 0);
    do_reset(1'b1, 1'b1);
    run_cycle(3'h1, 1'b1, 0);
  endtask
  // Compatible timing with grant given
  task automatic t_compat();
    do_reset(1'b1, 1'b0);
    run_cycle(3'h5, 1'b1, 0);
    run_cycle(3'h6, 1'b1, 0);
    run_cycle(3'h0, 1'b1, 0);
  endtask
  // Counts and verdict
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset(1'b0, 1'b1);
    t_all_types();
    t_select_hold();
    t_gate_grant();
    t_compat();
    final_report();
  end
  // Hang guard, well past the expected run
  initial begin
    #60000;
    fails++;
    final_report();
  end
endmodule // cpu_bus_command_controller_tb
